// ---- rtl/uieid_defs.svh ----
// register offsets, field positions and reset values of the enable/identify block
`ifndef UIEID_DEFS_SVH
`define UIEID_DEFS_SVH
`define UIEID_OFF_IER 12'h004
`define UIEID_OFF_IIR 12'h008
`define UIEID_OFF_CTRL 12'h010
`define UIEID_OFF_STAT 12'h014
`define UIEID_OFF_MASK 12'h018
`define UIEID_CTRL_FIFO_EN 0
`define UIEID_CTRL_DIV_SEL 7
`define UIEID_CTRL_AUX 8
`define UIEID_IER_RX 0
`define UIEID_IER_TX 1
`define UIEID_IER_LS 2
`define UIEID_IER_MS 3
`define UIEID_SRC_RX 0
`define UIEID_SRC_TX 1
`define UIEID_SRC_LS 2
`define UIEID_SRC_MS 3
`define UIEID_SRC_CT 4
`define UIEID_IIR_ID_RST 4'h1
`define UIEID_IER_RST 4'h0
`define UIEID_DLH_RST 8'h00
`define UIEID_SRC_RST 5'h00
`endif

// ---- rtl/uieid_pkg.sv ----
// types shared by the enable/identify block
package uieid_pkg;
  typedef enum logic [3:0] {
    ID_MS = 4'h0,
    ID_NONE = 4'h1,
    ID_TX = 4'h2,
    ID_RX = 4'h4,
    ID_LS = 4'h6,
    ID_CT = 4'hc
  } uieid_id_t;
  typedef logic [4:0] uieid_src_t;
endpackage

// ---- rtl/uieid_src_if.sv ----
// interrupt source bundle between the top, the resolver and the status logic
`timescale 1ns/1ps
`default_nettype none
interface uieid_src_if;
  import uieid_pkg::*;
  logic [3:0] en;
  logic line_status;
  logic rx_data;
  logic char_timeout;
  logic tx_empty;
  logic tx_low;
  logic modem_status;
  logic fifo_en;
  logic aux;
  uieid_src_t pending;
  uieid_id_t next_id;
  modport prio (input en, line_status, rx_data, char_timeout, tx_empty, tx_low,
    modem_status, fifo_en, aux, output pending, next_id);
  modport irq (input pending);
endinterface
`default_nettype wire

// ---- rtl/uieid_prio.sv ----
// gates raw sources with their enables and resolves the pending identity
`timescale 1ns/1ps
`default_nettype none
`include "uieid_defs.svh"
module uieid_prio import uieid_pkg::*; (
  uieid_src_if.prio s
);
  logic tx_src;
  always_comb begin
    tx_src = s.aux ? s.tx_low : s.tx_empty;
    s.pending = `UIEID_SRC_RST;
    s.pending[`UIEID_SRC_LS] = s.line_status & s.en[`UIEID_IER_LS];
    s.pending[`UIEID_SRC_RX] = s.rx_data & s.en[`UIEID_IER_RX];
    s.pending[`UIEID_SRC_CT] = s.char_timeout & s.fifo_en & s.en[`UIEID_IER_RX];
    s.pending[`UIEID_SRC_TX] = tx_src & s.en[`UIEID_IER_TX];
    s.pending[`UIEID_SRC_MS] = s.modem_status & s.en[`UIEID_IER_MS];
    // modem status ranks last among real sources
    if (s.pending[`UIEID_SRC_LS]) begin
      s.next_id = ID_LS;
    end else if (s.pending[`UIEID_SRC_RX]) begin
      s.next_id = ID_RX;
    end else if (s.pending[`UIEID_SRC_CT]) begin
      s.next_id = ID_CT;
    end else if (s.pending[`UIEID_SRC_TX]) begin
      s.next_id = ID_TX;
    end else if (s.pending[`UIEID_SRC_MS]) begin
      s.next_id = ID_MS;
    end else begin
      s.next_id = ID_NONE;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/uieid_irq.sv ----
// sticky per-source status, write-one-to-clear, masked onto one level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "uieid_defs.svh"
module uieid_irq import uieid_pkg::*; #(
  parameter int NSRC = 5
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  uieid_src_if.irq s,
  input wire logic wr_stat,
  input wire logic wr_mask,
  input wire logic [NSRC-1:0] wdata,
  output logic [NSRC-1:0] stat,
  output logic [NSRC-1:0] mask,
  output logic irq
);
  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_bit
      // set wins over a clear in the same cycle
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          stat[i] <= 1'b0;
        end else begin
          stat[i] <= s.pending[i] | (stat[i] & ~(wr_stat & wdata[i]));
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= `UIEID_SRC_RST;
    end else if (wr_mask) begin
      mask <= wdata;
    end
  end
  // one cycle behind status; keeps the output a flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat & mask);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/uieid_top.sv ----
// interrupt enable / divisor high / interrupt identity block with apb slave
//
// How it works
// - divisor mode: shared byte is divisor high
// - select bit 7: 0 enables, 1 divisor
// - bit 3 gates modem status source
// - bit 2 gates line status, top priority
// - bit 1 gates transmit holding empty
// - bit 0 gates rx data and timeout
// - read-only identity register at 0x8
// - bits 7:6 fifo enabled, 5:4 zero
// - bits 3:0 show top pending enabled source
// - fixed id codes and priority, reset 0001
// - aux bit 8 picks tx low threshold
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uieid_defs.svh"
module uieid_top import uieid_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int NSRC = 5
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_status_cond,
  input wire logic rx_data_cond,
  input wire logic char_timeout_cond,
  input wire logic tx_empty_cond,
  input wire logic tx_low_cond,
  input wire logic modem_status_cond,
  output logic [7:0] divisor_high,
  output logic divisor_access_select,
  output logic [3:0] pending_id,
  output logic irq
);
  logic [3:0] irq_enable;
  logic fifo_en;
  logic aux_threshold_control;
  logic [NSRC-1:0] stat;
  logic [NSRC-1:0] mask;
  logic setup_ok;
  logic done;
  logic wr;
  logic [31:0] next_rdata;
  logic mapped;
  logic [11:0] addr;

  uieid_src_if s();

  assign s.en = irq_enable;
  assign s.line_status = line_status_cond;
  assign s.rx_data = rx_data_cond;
  assign s.char_timeout = char_timeout_cond;
  assign s.tx_empty = tx_empty_cond;
  assign s.tx_low = tx_low_cond;
  assign s.modem_status = modem_status_cond;
  assign s.fifo_en = fifo_en;
  assign s.aux = aux_threshold_control;

  uieid_prio u_prio (
    .s(s)
  );

  uieid_irq #(
    .NSRC(NSRC)
  ) u_irq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .s(s),
    .wr_stat(wr && addr == `UIEID_OFF_STAT),
    .wr_mask(wr && addr == `UIEID_OFF_MASK),
    .wdata(pwdata[NSRC-1:0]),
    .stat(stat),
    .mask(mask),
    .irq(irq)
  );

  // apb: one wait state, the answer is prepared while pready is low
  assign addr = 12'(paddr);
  assign setup_ok = psel & penable & ~pready;
  assign done = psel & penable & pready;
  assign wr = done & pwrite;

  always_comb begin
    next_rdata = 32'h0000_0000;
    mapped = 1'b1;
    case (addr)
      `UIEID_OFF_IER: begin
        if (divisor_access_select) begin
          next_rdata[7:0] = divisor_high;
        end else begin
          next_rdata[3:0] = irq_enable;
        end
      end
      `UIEID_OFF_IIR: begin
        next_rdata[7:6] = {2{fifo_en}};
        next_rdata[3:0] = pending_id;
      end
      `UIEID_OFF_CTRL: begin
        next_rdata[`UIEID_CTRL_FIFO_EN] = fifo_en;
        next_rdata[`UIEID_CTRL_DIV_SEL] = divisor_access_select;
        next_rdata[`UIEID_CTRL_AUX] = aux_threshold_control;
      end
      `UIEID_OFF_STAT: begin
        next_rdata[NSRC-1:0] = stat;
      end
      `UIEID_OFF_MASK: begin
        next_rdata[NSRC-1:0] = mask;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_ok;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ok) begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= ~mapped;
    end else if (done) begin
      pslverr <= 1'b0;
    end
  end

  // the shared offset steers the write by the select bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable <= `UIEID_IER_RST;
    end else if (wr && addr == `UIEID_OFF_IER && !divisor_access_select) begin
      irq_enable <= pwdata[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divisor_high <= `UIEID_DLH_RST;
    end else if (wr && addr == `UIEID_OFF_IER && divisor_access_select) begin
      divisor_high <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_en <= 1'b0;
      divisor_access_select <= 1'b0;
      aux_threshold_control <= 1'b0;
    end else if (wr && addr == `UIEID_OFF_CTRL) begin
      fifo_en <= pwdata[`UIEID_CTRL_FIFO_EN];
      divisor_access_select <= pwdata[`UIEID_CTRL_DIV_SEL];
      aux_threshold_control <= pwdata[`UIEID_CTRL_AUX];
    end
  end

  // identity is a flop, so a read sees the state of one cycle before
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_id <= `UIEID_IIR_ID_RST;
    end else begin
      pending_id <= s.next_id;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_dlh_write: assert property (
    wr && addr == `UIEID_OFF_IER && divisor_access_select
    |=> divisor_high == $past(pwdata[7:0]) && irq_enable == $past(irq_enable))
  else $error("divisor high not written");

  a_ier_write: assert property (
    wr && addr == `UIEID_OFF_IER && !divisor_access_select
    |=> irq_enable == $past(pwdata[3:0]) && $stable(divisor_high))
  else $error("enable write wrong");

  a_ms_gate: assert property (
    !irq_enable[`UIEID_IER_MS] |-> !s.pending[`UIEID_SRC_MS])
  else $error("modem status not gated");

  a_ls_first: assert property (
    line_status_cond && irq_enable[`UIEID_IER_LS] |=> pending_id == ID_LS)
  else $error("line status not first");

  a_tx_gate: assert property (
    !irq_enable[`UIEID_IER_TX] |-> !s.pending[`UIEID_SRC_TX])
  else $error("tx empty not gated");

  a_ct_fifo: assert property (
    s.pending[`UIEID_SRC_CT] |-> fifo_en && irq_enable[`UIEID_IER_RX])
  else $error("timeout without fifo or enable");

  a_ier_upper: assert property (
    done && !pwrite && addr == `UIEID_OFF_IER |-> prdata[31:8] == 24'h000000)
  else $error("upper enable bits not zero");

  a_iir_read: assert property (
    done && !pwrite && addr == `UIEID_OFF_IIR |-> prdata[3:0] == $past(pending_id)
    && !pslverr)
  else $error("identity read wrong");

  a_iir_fifo: assert property (
    done && !pwrite && addr == `UIEID_OFF_IIR
    |-> prdata[7:6] == {2{$past(fifo_en)}} && prdata[5:4] == 2'h0)
  else $error("fifo bits wrong");

  a_none_pend: assert property (
    s.pending == `UIEID_SRC_RST |=> pending_id == ID_NONE)
  else $error("idle id not 0001");

  a_rx_second: assert property (
    !s.pending[`UIEID_SRC_LS] && s.pending[`UIEID_SRC_RX] |=> pending_id == ID_RX)
  else $error("rx data not second");

  a_aux_sel: assert property (
    aux_threshold_control && irq_enable[`UIEID_IER_TX]
    |-> s.pending[`UIEID_SRC_TX] == tx_low_cond)
  else $error("tx threshold not selected");

  a_ms_last: assert property (
    (s.pending & 5'h17) != 5'h00 |=> pending_id != ID_MS)
  else $error("modem status outranks");

  a_pready_wait: assert property (
    psel && penable && !pready |=> pready)
  else $error("no answer after access");

  a_pready_pulse: assert property (
    pready |=> !pready)
  else $error("ready longer than one cycle");

  a_slverr_map: assert property (
    done |-> pslverr == !mapped)
  else $error("error flag wrong for address");

  a_wr_zero: assert property (
    done && pwrite |-> prdata == 32'h0000_0000)
  else $error("write returned data");

  a_iir_ro: assert property (
    wr && addr == `UIEID_OFF_IIR |=> $stable(irq_enable) && $stable(divisor_high))
  else $error("identity write changed state");

  a_iir_upper: assert property (
    done && !pwrite && addr == `UIEID_OFF_IIR |-> prdata[31:8] == 24'h000000)
  else $error("upper identity bits not zero");

  a_dlh_read: assert property (
    done && !pwrite && addr == `UIEID_OFF_IER && $past(divisor_access_select)
    |-> prdata[7:0] == $past(divisor_high))
  else $error("divisor high read wrong");

  a_ier_read: assert property (
    done && !pwrite && addr == `UIEID_OFF_IER && !$past(divisor_access_select)
    |-> prdata[7:0] == {4'h0, $past(irq_enable)})
  else $error("enable read wrong");

  a_ls_gate: assert property (
    !irq_enable[`UIEID_IER_LS] |-> !s.pending[`UIEID_SRC_LS])
  else $error("line status not gated");

  a_rx_gate: assert property (
    !irq_enable[`UIEID_IER_RX] |-> !s.pending[`UIEID_SRC_RX] && !s.pending[`UIEID_SRC_CT])
  else $error("rx data or timeout not gated");

  a_tx_empty: assert property (
    !aux_threshold_control && irq_enable[`UIEID_IER_TX]
    |-> s.pending[`UIEID_SRC_TX] == tx_empty_cond)
  else $error("tx empty source wrong");

  a_ct_third: assert property (
    s.pending[`UIEID_SRC_CT] && !s.pending[`UIEID_SRC_LS] && !s.pending[`UIEID_SRC_RX]
    |=> pending_id == ID_CT)
  else $error("timeout not third");

  a_tx_fourth: assert property (
    s.pending[`UIEID_SRC_TX] && (s.pending & 5'h15) == 5'h00 |=> pending_id == ID_TX)
  else $error("tx empty not fourth");

  a_ms_fifth: assert property (
    s.pending == 5'h08 |=> pending_id == ID_MS)
  else $error("modem status not reported");

  a_stat_sticky: assert property (
    s.pending[`UIEID_SRC_RX] |=> stat[`UIEID_SRC_RX])
  else $error("status bit not set");

  a_irq_follow: assert property (
    (stat & mask) != 5'h00 |=> irq)
  else $error("interrupt not raised");

  a_irq_quiet: assert property (
    (stat & mask) == 5'h00 |=> !irq)
  else $error("interrupt without source");

  c_dlh_write: cover property (wr && addr == `UIEID_OFF_IER && divisor_access_select);
  c_id_ct: cover property (pending_id == ID_CT);
  c_id_ms: cover property (pending_id == ID_MS);
  c_irq: cover property (irq);
  c_slverr: cover property (done && pslverr);
endmodule
`default_nettype wire

// ---- test/uart_irq_enable_identify_bench.sv ----
// self-checking bench for the enable/identify block
`timescale 1ns/1ps
`default_nettype none
module uart_irq_enable_identify_bench;
  import uieid_pkg::*;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, irq, divisor_access_select;
  logic ls = 0, rx = 0, ct = 0, te = 0, tl = 0, ms = 0;
  logic [7:0] divisor_high;
  logic [3:0] pending_id, en;
  logic fe, ax;
  logic [31:0] r;
  int n_fail = 0, samples_checked = 0, seed = 99847;
  uieid_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_status_cond(ls), .rx_data_cond(rx), .char_timeout_cond(ct),
    .tx_empty_cond(te), .tx_low_cond(tl), .modem_status_cond(ms),
    .divisor_high(divisor_high), .divisor_access_select(divisor_access_select),
    .pending_id(pending_id), .irq(irq));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; waits for pready, never assumes the wait count
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // expected identity from raw levels, enables and fifo/aux settings
  function automatic logic [3:0] exp_id(input logic [3:0] e, input logic f, input logic a);
    if (ls && e[2]) return 4'h6;
    if (rx && e[0]) return 4'h4;
    if (ct && e[0] && f) return 4'hc;
    if ((a ? tl : te) && e[1]) return 4'h2;
    if (ms && e[3]) return 4'h0;
    return 4'h1;
  endfunction
  initial begin
    wait_clk(12);
    rst_n <= 1;
    check(pending_id, 32'h1);
    apb(0, 12'h004, 0);
    check(rd, 32'h0);
    apb(0, 12'h008, 0);
    check(rd, 32'h1);
    apb(1, 12'h008, 32'hffffffff);
    apb(0, 12'h008, 0);
    check(rd, 32'h1);
    apb(0, 12'h00c, 0);
    check(err, 1);
    check(rd, 32'h0);
    apb(1, 12'h004, 32'hffffffff);
    apb(0, 12'h004, 0);
    check(rd, 32'h0f);
    // divisor view keeps its own storage, enables survive the switch
    r = $random(seed);
    apb(1, 12'h010, 32'h80);
    // the write lands at the edge that ends the access; look one edge later
    wait_clk(1);
    check(divisor_access_select, 1);
    apb(1, 12'h004, r);
    wait_clk(1);
    check(divisor_high, r[7:0]);
    apb(0, 12'h004, 0);
    check(rd, {24'h0, r[7:0]});
    apb(1, 12'h010, 32'h0);
    wait_clk(1);
    check(divisor_access_select, 0);
    apb(0, 12'h004, 0);
    check(rd, 32'h0f);
    for (int k = 0; k < 48; k++) begin
      r = $random(seed);
      en = (k < 6) ? 4'hf : r[3:0];
      fe = r[4];
      ax = r[5];
      apb(1, 12'h010, {23'h0, ax, 7'h0, fe});
      apb(1, 12'h004, {28'h0, en});
      if (k < 6) begin
        {ls, rx, ct, te, tl, ms} <= 6'h20 >> k;
      end else begin
        {ls, rx, ct, te, tl, ms} <= {r[8], r[9], r[10], r[11], r[12], r[13]};
      end
      wait_clk(3);
      check(pending_id, exp_id(en, fe, ax));
      apb(0, 12'h008, 0);
      check(rd, {24'h0, {2{fe}}, 2'b00, exp_id(en, fe, ax)});
    end
    {ls, rx, ct, te, tl, ms} <= 6'h0;
    apb(1, 12'h004, 32'h0f);
    apb(1, 12'h014, 32'h1f);
    apb(1, 12'h018, 32'h01);
    wait_clk(2);
    check(irq, 0);
    // one-cycle event must stay latched after the source drops
    @(posedge ref_clk);
    rx <= 1;
    @(posedge ref_clk);
    rx <= 0;
    wait_clk(3);
    check(irq, 1);
    apb(0, 12'h014, 0);
    check(rd, 32'h01);
    apb(1, 12'h018, 32'h0);
    wait_clk(2);
    check(irq, 0);
    apb(1, 12'h018, 32'h01);
    wait_clk(2);
    check(irq, 1);
    apb(1, 12'h014, 32'h01);
    wait_clk(2);
    check(irq, 0);
    apb(0, 12'h014, 0);
    check(rd, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
